// *** shared/dac_link_consts.svh ***
// constants shared by the serial converter write link and its host
`ifndef DAC_LINK_CONSTS_SVH
`define DAC_LINK_CONSTS_SVH

// ********************
// command word layout
// ********************
`define WORD_BITS 16
`define COUNT_W 5
`define CODE_BITS 12
`define FLD_DISABLE 15
`define FLD_BUF 14
`define FLD_GAIN 13
`define FLD_ACTIVE 12
`define CODE_MSB 11
`define CMD_RESET 16'h0000

// ********************
// timing
// ********************
`define CORE_PERIOD_NS 40
`define SCK_HALF_NS 160
`define SCK_HALF_CYCLES ((`SCK_HALF_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define TIMER_W 3
`define BIT_IDX_W 4

// ********************
// host register map
// ********************
`define ADDR_W 4
`define REG_COMMAND 4'h0
`define REG_CONTROL 4'h4
`define REG_STATUS 4'h8
`define REG_LOAD 4'hC
`define CTL_AUTO_LOAD 0
`define CTL_HOLD_LOAD 1
`define CTL_IDLE_HIGH 2
`define CTL_W 3
`define CTL_RESET 3'h1
`define STS_BUSY 0
`define STS_SENT 1
`endif

// *** shared/dac_link_pkg.sv ***
// types of the serial converter write link
package dac_link_pkg;
`include "dac_link_consts.svh"

    // three-stage pin synchroniser with agreement filter
    typedef struct packed {
        logic stage1;
        logic stage2;
        logic stage3;
        logic level;
    } sync_state_t;

    // device receiver and latches
    typedef struct packed {
        logic sckPrev;
        logic csPrev;
        logic [`WORD_BITS-1:0] shiftReg;
        logic [`COUNT_W-1:0] bitCount;
        logic [`WORD_BITS-1:0] inputReg;
        logic refBuffered;
        logic gainSelN;
        logic outputActive;
        logic [`CODE_BITS-1:0] dacCode;
        logic ampEnable;
        logic loadSwitch;
        logic wordLatched;
        logic frameDropped;
        logic commandIgnored;
    } dev_state_t;

    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP, H_STROBE} host_phase_t;

    // host controller
    typedef struct packed {
        host_phase_t phase;
        logic [`TIMER_W-1:0] timer;
        logic [`BIT_IDX_W-1:0] bitIdx;
        logic [`WORD_BITS-1:0] txWord;
        logic csN;
        logic sck;
        logic serialIn;
        logic loadN;
        logic [`CTL_W-1:0] control;
        logic sent;
        logic waitReq;
        logic [31:0] readData;
    } host_state_t;
endpackage

// *** shared/dac_link_if.sv ***
// four-wire write link between host and converter
`timescale 1ns/10ps
`default_nettype none
interface dac_link_if;
    logic csN;
    logic sck;
    logic serialIn;
    logic loadN;

    modport host (output csN, output sck, output serialIn, output loadN);
    modport device (input csN, input sck, input serialIn, input loadN);
endinterface
`default_nettype wire

// *** verilog/pin_sync.sv ***
// three-flop pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic pinIn, // asynchronous pin
    output logic level // filtered level
);
    dac_link_pkg::sync_state_t s;
    dac_link_pkg::sync_state_t next_s;

    // stage1 feeds only stage2 so metastability stays contained
    always_comb begin
        next_s = s;
        next_s.stage1 = pinIn;
        next_s.stage2 = s.stage1;
        next_s.stage3 = s.stage2;
        if (s.stage2 == s.stage3) begin
            next_s.level = s.stage3;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= '{RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;
endmodule
`default_nettype wire

// *** verilog/dac_write_device.sv ***
// converter end of the link: serial receiver, input register and output register
`timescale 1ns/10ps
`default_nettype none
`include "dac_link_consts.svh"
module dac_write_device #(
    parameter int RESOLUTION = 12
) (
    input wire logic core_clk, // system clock, 25 MHz
    input wire logic reset, // power-on reset, synchronous, high
    dac_link_if.device link, // serial write link from the host
    // output register and analog stage controls
    output logic [`CODE_BITS-1:0] dacCode, // code held by the output register
    output logic refBuffered, // reference buffer in use
    output logic gainSelN, // 1 unity gain, 0 double gain
    output logic outputActive, // converter output active
    output logic ampEnable, // output amplifier enable
    output logic loadSwitch, // output tied to resistive load
    // one-cycle event pulses
    output logic wordLatched, // pulse: input register updated
    output logic frameDropped, // pulse: short frame discarded
    output logic commandIgnored // pulse: disabled command dropped
);
    // ********************
    // overview
    // ********************
    // pins have no timing relation to core_clk:
    // all decisions use filtered levels, at the
    // cost of a few cycles on each pin event
    //
    // one frame:
    //   select falls - count starts at zero
    //   sixteen rises - word complete
    //   select rises - full word to input register
    //   strobe low - input copied to output
    //
    // the strobe is a level: held low, each
    // latched word passes through at once
    //
    // narrow variants keep the code left aligned
    // and clear the unused low bits here
    //
    // the analog stage is not modelled: only its
    // two controls leave the output register

    // ********************
    // constants
    // ********************
    // low code bits of narrower variants read as zero
    // for twelve bits the mask is all ones
    localparam logic [`CODE_BITS-1:0] CODE_MASK =
        `CODE_BITS'({`CODE_BITS{1'b1}} << (`CODE_BITS - RESOLUTION));

    // the count stops here; five bits hold sixteen itself
    localparam logic [`COUNT_W-1:0] FULL_COUNT = `COUNT_W'(`WORD_BITS);

    // shutdown, double gain, unbuffered, empty input register
    localparam dac_link_pkg::dev_state_t DEV_RESET = '{
        csPrev: 1'b1,
        loadSwitch: 1'b1,
        inputReg: `CMD_RESET,
        default: '0
    };

    // ********************
    // pin synchronisers
    // ********************
    // filtered pin levels, four cycles behind the pins
    logic csLevel;
    logic sckLevel;
    logic dataLevel;
    logic loadLevel;

    // every pin crosses from the host's timing into ours
    // four filters, one per pin, alike but for their reset levels
    // select resets high, its idle level, so no frame starts
    pin_sync #(.RESET_LEVEL(1'b1)) csSync (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn(link.csN),
        .level(csLevel)
    );

    // clock resets low; a host idling high shows one rise
    // while deselected, which the receiver ignores
    pin_sync #(.RESET_LEVEL(1'b0)) sckSync (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn(link.sck),
        .level(sckLevel)
    );

    // data takes the same path so it lines up with the clock edge
    // its reset level is moot: nothing shifts until select falls
    pin_sync #(.RESET_LEVEL(1'b0)) dataSync (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn(link.serialIn),
        .level(dataLevel)
    );

    // strobe resets high so the output holds while filters refill
    pin_sync #(.RESET_LEVEL(1'b1)) loadSync (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn(link.loadN),
        .level(loadLevel)
    );

    // ********************
    // state
    // ********************
    // all receiver registers sit in one struct
    dac_link_pkg::dev_state_t s;
    dac_link_pkg::dev_state_t next_s;
    logic sckRise; // filtered clock went high
    logic csRise; // filtered select went high
    logic frameFull; // sixteen bits are in

    // edges are seen on filtered levels only; sckPrev and csPrev reset
    // to the idle levels of their pins, so no false edge follows reset
    // frameFull also gates the latch, so short frames never land
    assign sckRise = sckLevel && !s.sckPrev;
    assign csRise = csLevel && !s.csPrev;
    assign frameFull = (s.bitCount == FULL_COUNT);

    // ********************
    // receiver and latches
    // ********************
    // there is no data output: nothing is ever driven back to the host
    // one process for the whole receiver keeps the update order plain
    always_comb begin
        next_s = s; // anything not named below keeps its value
        next_s.sckPrev = sckLevel;
        next_s.csPrev = csLevel;

        // event pulses last one cycle unless set again below
        next_s.wordLatched = 1'b0;
        next_s.frameDropped = 1'b0;
        next_s.commandIgnored = 1'b0;

        // shifting runs in any power state, shutdown included
        // deselect holds the count at zero, so each frame starts clean
        if (csLevel) begin
            next_s.bitCount = '0;
        end else if (sckRise && !frameFull) begin
            // the count stops at sixteen: later rises change nothing
            // first bit in ends up as the top bit of the word
            next_s.shiftReg = {s.shiftReg[`WORD_BITS-2:0], dataLevel};
            next_s.bitCount = s.bitCount + `COUNT_W'(1);
        end

        // select rising closes the frame; only a full one is taken
        if (csRise) begin
            if (!frameFull) begin
                // a cut frame leaves the input register as it was
                next_s.frameDropped = 1'b1;
            end else if (s.shiftReg[`FLD_DISABLE]) begin
                // a disabled word is dropped whole, settings included
                next_s.commandIgnored = 1'b1;
            end else begin
                // only here does a new word reach the input register
                next_s.inputReg = s.shiftReg;
                next_s.wordLatched = 1'b1;
            end
        end

        // level sensitive copy, so a strobe held low passes the new word
        // through on the very edge that latches it
        if (!loadLevel) begin
            // the whole word moves at once, so settings and
            // code never mix two commands
            next_s.refBuffered = next_s.inputReg[`FLD_BUF];
            next_s.gainSelN = next_s.inputReg[`FLD_GAIN];
            next_s.outputActive = next_s.inputReg[`FLD_ACTIVE];
            // straight binary, unused low bits dropped
            next_s.dacCode = next_s.inputReg[`CODE_MSB:0] & CODE_MASK;
        end

        // the analog stage follows the output register only
        // in shutdown the amplifier is off and the load is on
        next_s.ampEnable = next_s.outputActive;
        next_s.loadSwitch = !next_s.outputActive;
    end

    // reset leaves the part in shutdown with double gain, unbuffered
    // the filters are loaded with their reset levels during reset and refill after it,
    // so allow four cycles after reset before the first frame
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= DEV_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ********************
    // outputs
    // ********************
    // every output is a register bit, so nothing downstream glitches
    assign dacCode = s.dacCode;
    assign refBuffered = s.refBuffered;
    assign gainSelN = s.gainSelN;
    assign outputActive = s.outputActive;
    assign ampEnable = s.ampEnable;
    assign loadSwitch = s.loadSwitch;

    // one-cycle event pulses, for status or counting outside
    assign wordLatched = s.wordLatched;
    assign frameDropped = s.frameDropped;
    assign commandIgnored = s.commandIgnored;
endmodule
`default_nettype wire

// *** verilog/dac_spi_host.sv ***
// host end of the link: Avalon-MM slave registers driving a serial write master
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dac_link_consts.svh"
module dac_spi_host (
    input wire logic core_clk, // system clock, 25 MHz
    input wire logic reset, // synchronous, active high
    input wire logic [`ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // high until request taken
    dac_link_if.host link // serial write link to the converter
);
    localparam logic [`TIMER_W-1:0] HALF_LAST = `TIMER_W'(`SCK_HALF_CYCLES - 1);
    localparam logic [`BIT_IDX_W-1:0] LAST_BIT = `BIT_IDX_W'(`WORD_BITS - 1);
    localparam dac_link_pkg::host_state_t HOST_RESET = '{
        phase: dac_link_pkg::H_IDLE,
        csN: 1'b1,
        loadN: 1'b1,
        control: `CTL_RESET,
        waitReq: 1'b1,
        default: '0
    };

    dac_link_pkg::host_state_t s;
    dac_link_pkg::host_state_t next_s;
    logic halfDone;
    logic idleHigh;
    logic busy;
    logic stall;

    assign halfDone = (s.timer == HALF_LAST);
    assign idleHigh = s.control[`CTL_IDLE_HIGH];
    assign busy = (s.phase != dac_link_pkg::H_IDLE);
    // new frames wait while one is running, which back-pressures software
    assign stall = avs_write && busy &&
        (avs_address == `REG_COMMAND || avs_address == `REG_LOAD);

    // ********************
    // serial engine and bus slave
    // ********************
    always_comb begin
        next_s = s;
        next_s.timer = halfDone ? '0 : s.timer + `TIMER_W'(1);
        next_s.waitReq = 1'b1;
        unique case (s.phase)
            dac_link_pkg::H_IDLE: begin
                next_s.timer = '0;
                next_s.sck = idleHigh;
                next_s.loadN = !s.control[`CTL_HOLD_LOAD];
            end
            dac_link_pkg::H_LEAD: begin
                if (halfDone) begin
                    next_s.phase = dac_link_pkg::H_LOW;
                    next_s.sck = 1'b0;
                end
            end
            dac_link_pkg::H_LOW: begin
                // data has been steady a full half period before this rise
                if (halfDone) begin
                    next_s.phase = dac_link_pkg::H_HIGH;
                    next_s.sck = 1'b1;
                end
            end
            dac_link_pkg::H_HIGH: begin
                if (halfDone && s.bitIdx == LAST_BIT) begin
                    next_s.phase = dac_link_pkg::H_TAIL;
                    next_s.sck = idleHigh;
                end else if (halfDone) begin
                    next_s.phase = dac_link_pkg::H_LOW;
                    next_s.sck = 1'b0;
                    next_s.bitIdx = s.bitIdx + `BIT_IDX_W'(1);
                    next_s.txWord = {s.txWord[`WORD_BITS-2:0], 1'b0};
                    next_s.serialIn = s.txWord[`WORD_BITS-2];
                end
            end
            dac_link_pkg::H_TAIL: begin
                // select stays low until after the last rise
                if (halfDone) begin
                    next_s.phase = dac_link_pkg::H_GAP;
                    next_s.csN = 1'b1;
                end
            end
            dac_link_pkg::H_GAP: begin
                if (halfDone) begin
                    next_s.sent = 1'b1;
                    next_s.phase = s.control[`CTL_AUTO_LOAD] ?
                        dac_link_pkg::H_STROBE : dac_link_pkg::H_IDLE;
                    next_s.loadN = !s.control[`CTL_AUTO_LOAD] && !s.control[`CTL_HOLD_LOAD];
                end
            end
            dac_link_pkg::H_STROBE: begin
                if (halfDone) begin
                    next_s.phase = dac_link_pkg::H_IDLE;
                    next_s.loadN = !s.control[`CTL_HOLD_LOAD];
                end
            end
        endcase

        // one wait cycle per access; read data stand when it drops
        if ((avs_read || avs_write) && s.waitReq && !stall) begin
            next_s.waitReq = 1'b0;
            next_s.readData = '0;
            if (avs_read && avs_address == `REG_CONTROL) begin
                next_s.readData[`CTL_W-1:0] = s.control;
            end else if (avs_read && avs_address == `REG_STATUS) begin
                next_s.readData[`STS_BUSY] = busy;
                next_s.readData[`STS_SENT] = s.sent;
            end
        end

        // a write takes effect on the edge that sees waitrequest low
        if (avs_write && !s.waitReq) begin
            if (avs_address == `REG_COMMAND) begin
                next_s.phase = dac_link_pkg::H_LEAD;
                next_s.timer = '0;
                next_s.bitIdx = '0;
                next_s.sent = 1'b0;
                next_s.csN = 1'b0;
                next_s.txWord = avs_writedata[`WORD_BITS-1:0];
                next_s.serialIn = avs_writedata[`WORD_BITS-1];
            end else if (avs_address == `REG_CONTROL) begin
                next_s.control = avs_writedata[`CTL_W-1:0];
            end else if (avs_address == `REG_LOAD) begin
                next_s.phase = dac_link_pkg::H_STROBE;
                next_s.timer = '0;
                next_s.loadN = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= HOST_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata = s.readData;
    assign avs_waitrequest = s.waitReq;
    assign link.csN = s.csN;
    assign link.sck = s.sck;
    assign link.serialIn = s.serialIn;
    assign link.loadN = s.loadN;
endmodule
`default_nettype wire

// *** verification/dac_link_chk.sv ***
// assertions on the host-to-converter link and the converter outputs
`timescale 1ns/10ps
`default_nettype none
`include "dac_link_consts.svh"
module dac_link_chk (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic csN, // chip select, active low
    input wire logic sck, // serial clock
    input wire logic serialIn, // serial data
    input wire logic loadN, // load strobe, active low
    input wire logic [`CODE_BITS-1:0] dacCode, // output register code
    input wire logic outputActive, // output active
    input wire logic ampEnable, // amplifier enable
    input wire logic loadSwitch, // resistive load on
    input wire logic wordLatched, // input register updated
    input wire logic frameDropped, // short frame discarded
    input wire logic commandIgnored // disabled command dropped
);
    logic [4:0] riseCnt;
    logic [3:0] loadAge;

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // ****************
    // helper counters
    // ****************
    // clock rises in the current frame, and cycles since the strobe was last seen low
    always_ff @(posedge core_clk) begin
        if (reset || csN) begin
            riseCnt <= 5'h00;
        end else if ($rose(sck)) begin
            riseCnt <= riseCnt + 5'h01;
        end
        if (reset || !loadN) begin
            loadAge <= 4'h0;
        end else if (loadAge != 4'hF) begin
            loadAge <= loadAge + 4'h1;
        end
    end

    AST_STAGE_FOLLOWS: assert property (ampEnable == outputActive && loadSwitch == !outputActive)
        else $error("output stage does not follow the active bit");
    AST_RESET_STATE: assert property ($fell(reset) |-> !outputActive && loadSwitch && dacCode == 12'h000)
        else $error("converter not in shutdown after reset");
    AST_SIXTEEN_RISES: assert property ($rose(csN) |-> riseCnt == 5'h10)
        else $error("frame did not carry sixteen clock rises");
    AST_LATCH_AFTER_SELECT: assert property ($rose(csN) |-> ##[3:8] (wordLatched || commandIgnored))
        else $error("complete frame not taken after select rose");
    AST_EVENT_DESELECTED: assert property ((wordLatched || frameDropped || commandIgnored) |-> csN)
        else $error("frame event while still selected");
    AST_HOST_FULL: assert property (!frameDropped)
        else $error("host sent a short frame");
    AST_DATA_STEADY: assert property ($rose(sck) && !csN |-> $stable(serialIn)[*4])
        else $error("serial data moved around the sampling edge");
    AST_LEAD: assert property ($fell(csN) |-> $stable(sck)[*3])
        else $error("clock moved right after select fell");
    AST_CODE_NEEDS_LOAD: assert property ($changed(dacCode) |-> loadAge < 4'h8)
        else $error("output code changed without the load strobe");
    AST_WAKE_NEEDS_LOAD: assert property ($rose(outputActive) |-> loadAge < 4'h8)
        else $error("left shutdown without the load strobe");

    cover property (wordLatched);
    cover property (commandIgnored);
    cover property ($rose(outputActive));
endmodule
`default_nettype wire

// *** verification/serial_dac_write_latch_tb_top.sv ***
// testbench: host and converter back to back, plus a bit-banged narrow converter
`timescale 1ns/10ps
`default_nettype none
`include "dac_link_consts.svh"
module serial_dac_write_latch_tb_top;
    logic core_clk;
    logic reset;
    logic [`ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [11:0] codeA;
    logic [11:0] codeB;
    logic actA, ampA, swA, bufA, gainA, latA, dropA, ignA, latB, dropB;
    int n_errors = 0;
    int n_compared = 0;
    int evA = 0;
    int evB = 0;
    int ignCntA = 0;
    int dropCntB = 0;
    int expIgn = 0;
    logic [15:0] inReg = 16'h0000;
    logic [15:0] outReg = 16'h0000;

    dac_link_if linkA();
    dac_link_if linkB();
    dac_spi_host i_dac_spi_host (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(linkA));
    dac_write_device i_dac_write_device (.core_clk(core_clk), .reset(reset), .link(linkA), .dacCode(codeA),
        .refBuffered(bufA), .gainSelN(gainA), .outputActive(actA), .ampEnable(ampA), .loadSwitch(swA),
        .wordLatched(latA), .frameDropped(dropA), .commandIgnored(ignA));
    // narrow variant driven by the bench so that faulty frames can be sent
    dac_write_device #(.RESOLUTION(8)) i_dac_write_device_2 (.core_clk(core_clk), .reset(reset), .link(linkB),
        .dacCode(codeB), .refBuffered(), .gainSelN(), .outputActive(), .ampEnable(), .loadSwitch(),
        .wordLatched(latB), .frameDropped(dropB), .commandIgnored());
    dac_link_chk i_dac_link_chk (.core_clk(core_clk), .reset(reset), .csN(linkA.csN), .sck(linkA.sck),
        .serialIn(linkA.serialIn), .loadN(linkA.loadN), .dacCode(codeA), .outputActive(actA),
        .ampEnable(ampA), .loadSwitch(swA), .wordLatched(latA), .frameDropped(dropA), .commandIgnored(ignA));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // frame events of both converters, counted one edge late to avoid races
    always @(posedge core_clk) begin
        if (latA === 1'b1 || ignA === 1'b1) evA <= evA + 1;
        if (ignA === 1'b1) ignCntA <= ignCntA + 1;
        if (latB === 1'b1 || dropB === 1'b1) evB <= evB + 1;
        if (dropB === 1'b1) dropCntB <= dropCntB + 1;
    end

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one Avalon access; a busy host may stall a frame-length time
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        for (i = 0; i < 400; i++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 400) begin
            n_errors++;
            wrap_up();
        end
    endtask

    task automatic waitEv(input bit onB, input int base);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge core_clk);
            if ((onB ? evB : evA) != base) break;
        end
        if (i == 400) begin
            n_errors++;
            wrap_up();
        end
    endtask

    task automatic checkA;
        chk("code", {4'h0, outReg[11:0]}, {4'h0, codeA});
        chk("mode bits", {13'h0, outReg[14:12]}, {13'h0, bufA, gainA, actA});
        chk("stage", {14'h0, outReg[12], !outReg[12]}, {14'h0, ampA, swA});
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic reset_state;
        logic [31:0] q;
        checkA;
        chk("narrow code", 16'h0000, {4'h0, codeB});
        avs(1'b1, 4'h2, 32'hFFFF_FFFF, q);
        avs(1'b0, 4'h2, 32'h0, q);
        chk("unmapped", 16'h0000, q[15:0]);
        avs(1'b0, `REG_CONTROL, 32'h0, q);
        chk("control reset", 16'h0001, q[15:0]);
    endtask

    // host frames: held load, ignored word, shutdown in mode 1,1, wake at full scale, load held low
    task automatic host_table;
        logic [2:0] ctl [5] = '{3'h0, 3'h1, 3'h5, 3'h5, 3'h2};
        logic [15:0] wd [5] = '{16'h3ABC, 16'hF123, 16'h4555, 16'h1FFF, 16'h2000};
        logic [31:0] q;
        int base;
        for (int k = 0; k < 5; k++) begin
            avs(1'b1, `REG_CONTROL, {29'h0, ctl[k]}, q);
            avs(1'b0, `REG_CONTROL, 32'h0, q);
            chk("control", {13'h0, ctl[k]}, q[15:0]);
            base = evA;
            avs(1'b1, `REG_COMMAND, {16'hA5A5, wd[k]}, q);
            waitEv(1'b0, base);
            repeat (12) @(posedge core_clk); // load pulse of 4 cycles plus the pin filter
            if (!wd[k][15]) inReg = wd[k];
            if (wd[k][15]) expIgn++;
            if (ctl[k][0] || ctl[k][1]) outReg = inReg;
            avs(1'b0, `REG_STATUS, 32'h0, q);
            chk("status", 16'h0002, {14'h0, q[1:0]});
            checkA;
            chk("ignores", 16'(expIgn), 16'(ignCntA));
            if (k == 0) begin
                avs(1'b1, `REG_LOAD, 32'h0, q);
                repeat (12) @(posedge core_clk);
                outReg = inReg;
                checkA;
            end
        end
    endtask

    // bench frame on the second link: stray clocks while deselected, then n clocks of w
    task automatic bang(input logic [15:0] w, input int n);
        for (int i = 0; i < 6; i++) begin
            linkB.sck <= !i[0];
            linkB.serialIn <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
        linkB.csN <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            linkB.sck <= 1'b0;
            linkB.serialIn <= (i < 16) ? w[4'(15 - i)] : !w[0];
            repeat (4) @(posedge core_clk);
            linkB.sck <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
        linkB.sck <= 1'b0;
        repeat (4) @(posedge core_clk);
        linkB.csN <= 1'b1;
        linkB.serialIn <= !linkB.serialIn; // released data line shows the inverse
    endtask

    task automatic narrow_link;
        logic [15:0] w [3] = '{16'h1ABC, 16'h1123, 16'h1456};
        int n [3] = '{16, 10, 20};
        logic [11:0] expCode = 12'h000;
        int base;
        for (int k = 0; k < 3; k++) begin
            base = evB;
            bang(w[k], n[k]);
            waitEv(1'b1, base);
            repeat (8) @(posedge core_clk);
            if (n[k] >= 16) expCode = w[k][11:0] & 12'hFF0;
            chk("narrow code", {4'h0, expCode}, {4'h0, codeB});
        end
        chk("narrow drops", 16'h0001, 16'(dropCntB));
    endtask

    // main sequence
    initial begin
        reset = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        linkB.csN = 1'b1;
        linkB.sck = 1'b0;
        linkB.serialIn = 1'b0;
        linkB.loadN = 1'b0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        reset_state;
        host_table;
        narrow_link;
        wrap_up;
    end
endmodule
`default_nettype wire
